//--- rtl/ccmh_top.sv
/*
 * config-mode command handler: mode pins, 9600 8N1 uart, command parser,
 * working and retained parameter banks, busy indicator.
 * assumes pins synchronous to clock and a radio datapath that reports
 * pending transfers on xfer_pending.
 */
`timescale 1ns/1ps
module ccmh_top #(
    parameter int BIT_CYCLES = ccmh_pkg::BIT_CYC,
    parameter int SWITCH_CYCLES = ccmh_pkg::SWITCH_CYC,
    parameter int RECONF_CYCLES = ccmh_pkg::RECONF_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // mode pins and radio status
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic xfer_pending,
    // serial pins and busy indicator
    input wire logic uart_rxd,
    output logic uart_txd,
    output logic aux_ready,
    // applied settings towards radio and uart, retained bank
    output logic [1:0] cur_mode,
    output logic radio_tx_en,
    output logic radio_rx_en,
    output logic [16:0] uart_baud,
    output logic [1:0] uart_parity,
    output logic [2:0] air_rate_sel,
    output logic [15:0] node_address,
    output logic addr_filter_en,
    output ccmh_pkg::ccmh_cfg_s retained_cfg
);
    import ccmh_pkg::*;

    typedef enum logic [2:0] {P_HDR, P_ADDR, P_LEN, P_DATA, P_REPLY} ccmh_st_e;

    function automatic logic [7:0] reg_get(ccmh_cfg_s c, logic [7:0] a);
        case (a)
            REG_ADDR_HI: reg_get = c.addr_hi;
            REG_ADDR_LO: reg_get = c.addr_lo;
            REG_SER_AIR: reg_get = c.ser_air;
            default: reg_get = 8'h00;
        endcase
    endfunction : reg_get

    localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
    localparam logic [15:0] SW_M1 = 16'(SWITCH_CYCLES - 1);
    localparam logic [15:0] RC_M1 = 16'(RECONF_CYCLES - 1);

    // ****************************************
    // state
    // ****************************************
    logic [1:0] mode_r, mode_nxt;
    logic [15:0] sw_cnt_r, sw_cnt_nxt, rc_cnt_r, rc_cnt_nxt;
    logic reconf_r, reconf_nxt, aux_r, aux_nxt;
    logic rx_act_r, rx_act_nxt, rx_vld_r, rx_vld_nxt;
    logic [15:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt, tx_left_r, tx_left_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    ccmh_st_e st_r, st_nxt;
    logic [7:0] hdr_r, hdr_nxt, addr_r, addr_nxt, len_r, len_nxt;
    logic [7:0] idx_r, idx_nxt, tx_byte;
    logic err_r, err_nxt, tx_go;
    logic [7:0] wbuf_r [3];
    logic [7:0] wbuf_nxt [3];
    ccmh_cfg_s work_r, work_nxt, ret_r, ret_nxt, act_r, act_nxt;
    logic [1:0] pin_mode;
    logic idle;
    logic [8:0] span;

    assign pin_mode = {mode_select_high, mode_select_low};
    assign idle = !xfer_pending && st_r != P_REPLY && tx_left_r == 4'h0
        && !rx_act_r && !reconf_r;

    // ****************************************
    // mode switching and reconfiguration
    // ****************************************
    always_comb begin
        mode_nxt = mode_r;
        sw_cnt_nxt = 16'h0000;
        reconf_nxt = reconf_r;
        rc_cnt_nxt = rc_cnt_r;
        act_nxt = act_r;
        if (pin_mode != mode_r && idle) begin
            sw_cnt_nxt = sw_cnt_r + 16'h0001;
            if (sw_cnt_r == SW_M1) begin
                sw_cnt_nxt = 16'h0000;
                mode_nxt = pin_mode;
                if (mode_r == MODE_CONFIG) begin
                    reconf_nxt = 1'b1;
                    rc_cnt_nxt = 16'h0000;
                end
            end
        end
        if (reconf_r) begin
            rc_cnt_nxt = rc_cnt_r + 16'h0001;
            if (rc_cnt_r == RC_M1) begin
                reconf_nxt = 1'b0;
                act_nxt = work_r;
            end
        end
        aux_nxt = !(reconf_nxt || xfer_pending || st_nxt == P_REPLY
            || tx_go || tx_left_r > 4'h1);
    end

    // ****************************************
    // uart receiver, fixed format
    // ****************************************
    always_comb begin
        rx_act_nxt = rx_act_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_vld_nxt = 1'b0;
        if (!rx_act_r) begin
            if (mode_r == MODE_CONFIG && !uart_rxd) begin
                rx_act_nxt = 1'b1;
                rx_cnt_nxt = BIT_HALF;
                rx_bit_nxt = 4'h0;
            end
        end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_nxt = rx_cnt_r - 16'h0001;
        end else begin
            rx_cnt_nxt = BIT_M1;
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
                rx_act_nxt = !uart_rxd; // glitch, not a start bit
            end else if (rx_bit_r < STOP_BIT) begin
                rx_sh_nxt = {uart_rxd, rx_sh_r[7:1]};
            end else begin
                rx_act_nxt = 1'b0;
                rx_vld_nxt = uart_rxd; // framing error drops byte
            end
        end
    end

    // ****************************************
    // uart transmitter
    // ****************************************
    always_comb begin
        tx_sh_nxt = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_left_nxt = tx_left_r;
        if (tx_go) begin
            tx_sh_nxt = {1'b1, tx_byte, 1'b0};
            tx_left_nxt = FRAME_BITS;
            tx_cnt_nxt = BIT_M1;
        end else if (tx_left_r != 4'h0) begin
            if (tx_cnt_r == 16'h0000) begin
                tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
                tx_left_nxt = tx_left_r - 4'h1;
                tx_cnt_nxt = BIT_M1;
            end else begin
                tx_cnt_nxt = tx_cnt_r - 16'h0001;
            end
        end
    end

    // ****************************************
    // command parser and parameter banks
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        hdr_nxt = hdr_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        idx_nxt = idx_r;
        err_nxt = err_r;
        wbuf_nxt = wbuf_r;
        work_nxt = work_r;
        ret_nxt = ret_r;
        tx_go = 1'b0;
        tx_byte = ERR_BYTE;
        span = {1'b0, addr_r} + {1'b0, rx_sh_r};
        case (st_r)
            P_HDR: if (rx_vld_r) begin
                idx_nxt = 8'h00;
                err_nxt = !(rx_sh_r == HDR_WRITE || rx_sh_r == HDR_READ
                    || rx_sh_r == HDR_TEMP);
                hdr_nxt = rx_sh_r;
                st_nxt = err_nxt ? P_REPLY : P_ADDR;
            end
            P_ADDR: if (rx_vld_r) begin
                addr_nxt = rx_sh_r;
                st_nxt = P_LEN;
            end
            P_LEN: if (rx_vld_r) begin
                len_nxt = rx_sh_r;
                err_nxt = rx_sh_r == 8'h00 || span > REG_COUNT;
                st_nxt = (err_nxt || hdr_r == HDR_READ) ? P_REPLY : P_DATA;
            end
            P_DATA: if (rx_vld_r) begin
                wbuf_nxt[2'(addr_r + idx_r)] = rx_sh_r;
                idx_nxt = idx_r + 8'h01;
                if (idx_nxt == len_r) begin
                    idx_nxt = 8'h00;
                    st_nxt = P_REPLY;
                    for (int i = 0; i < 3; i++) begin
                        if (i >= int'(addr_r) && i < int'(addr_r) + int'(len_r))
                        begin
                            case (8'(i))
                                REG_ADDR_HI: work_nxt.addr_hi = wbuf_nxt[i];
                                REG_ADDR_LO: work_nxt.addr_lo = wbuf_nxt[i];
                                default: work_nxt.ser_air = wbuf_nxt[i];
                            endcase
                        end
                    end
                    if (hdr_r == HDR_WRITE) begin
                        ret_nxt = work_nxt;
                    end // temporary write leaves ret alone
                end
            end
            P_REPLY: if (tx_left_r == 4'h0) begin
                tx_go = 1'b1;
                if (!err_r) begin
                    case (idx_r)
                        8'h00: tx_byte = HDR_READ;
                        8'h01: tx_byte = addr_r;
                        8'h02: tx_byte = len_r;
                        default: tx_byte = reg_get(work_r,
                            addr_r + idx_r - 8'h03);
                    endcase
                end
                idx_nxt = idx_r + 8'h01;
                if (idx_r == (err_r ? 8'h02 : len_r + 8'h02)) begin
                    st_nxt = P_HDR;
                end
            end
            default: st_nxt = P_HDR;
        endcase
        if (mode_r != MODE_CONFIG) begin
            st_nxt = P_HDR; // frames do not survive a mode change
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_r <= MODE_CONFIG;
            sw_cnt_r <= 16'h0000;
            rc_cnt_r <= 16'h0000;
            reconf_r <= 1'b0;
            aux_r <= 1'b0;
            act_r <= CFG_RST;
            work_r <= CFG_RST;
            ret_r <= CFG_RST;
            rx_act_r <= 1'b0;
            rx_vld_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 10'h3ff;
            tx_cnt_r <= 16'h0000;
            tx_left_r <= 4'h0;
            st_r <= P_HDR;
            hdr_r <= 8'h00;
            addr_r <= 8'h00;
            len_r <= 8'h00;
            idx_r <= 8'h00;
            err_r <= 1'b0;
            wbuf_r <= '{8'h00, 8'h00, 8'h00};
        end else begin
            mode_r <= mode_nxt;
            sw_cnt_r <= sw_cnt_nxt;
            rc_cnt_r <= rc_cnt_nxt;
            reconf_r <= reconf_nxt;
            aux_r <= aux_nxt;
            act_r <= act_nxt;
            work_r <= work_nxt;
            ret_r <= ret_nxt;
            rx_act_r <= rx_act_nxt;
            rx_vld_r <= rx_vld_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_left_r <= tx_left_nxt;
            st_r <= st_nxt;
            hdr_r <= hdr_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            idx_r <= idx_nxt;
            err_r <= err_nxt;
            wbuf_r <= wbuf_nxt;
        end
    end

    // ****************************************
    // outputs from serial, busy and mode state, applied settings and retained bank
    // ****************************************
    assign uart_txd = tx_sh_r[0];
    assign aux_ready = aux_r;
    assign cur_mode = mode_r;
    assign radio_rx_en = mode_r != MODE_CONFIG;
    assign radio_tx_en = mode_r == MODE_NORMAL || mode_r == MODE_WOR_TX;
    assign uart_baud = BAUD_TAB[act_r.ser_air[BAUD_MSB:BAUD_LSB]];
    assign uart_parity = act_r.ser_air[PAR_MSB:PAR_LSB] == PAR_ALIAS
        ? PAR_NONE : act_r.ser_air[PAR_MSB:PAR_LSB];
    assign air_rate_sel = act_r.ser_air[AIR_MSB:AIR_LSB] < AIR_SLOWEST
        ? AIR_SLOWEST : act_r.ser_air[AIR_MSB:AIR_LSB];
    assign node_address = {act_r.addr_hi, act_r.addr_lo};
    assign addr_filter_en = node_address != BCAST_ADDR;
    assign retained_cfg = ret_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_leave_cfg;
        mode_r == MODE_CONFIG ##1 mode_r != MODE_CONFIG;
    endsequence

    a_radio_off_cfg: assert property (mode_r == MODE_CONFIG |->
        !radio_tx_en && !radio_rx_en) else $error("radio on in mode 3");
    a_leave_busy_low: assert property (s_leave_cfg |-> reconf_r && !aux_r)
        else $error("busy not low on leaving sleep");
    a_reconf_apply: assert property ($fell(reconf_r) |->
        act_r == $past(work_r) && aux_r == !$past(xfer_pending))
        else $error("reconfiguration end wrong");
    a_switch_wait: assert property ($changed(mode_r) |->
        $past(sw_cnt_r) == SW_M1) else $error("mode switched early");
    a_bad_header: assert property (st_r == P_HDR && rx_vld_r
        && rx_sh_r != HDR_WRITE && rx_sh_r != HDR_READ
        && rx_sh_r != HDR_TEMP ##1 1'b1 |-> st_r == P_REPLY && err_r
        && $stable(work_r)) else $error("no error reply");
    a_retained_only: assert property ($changed(ret_r) |->
        $past(hdr_r) == HDR_WRITE) else $error("retained bank hit");
    a_settings_hold: assert property (mode_r == MODE_CONFIG |=>
        $stable(act_r)) else $error("settings moved in mode 3");
    a_rx_cfg_only: assert property (rx_vld_r |-> $past(mode_r) ==
        MODE_CONFIG) else $error("byte outside mode 3");
    a_reply_head: assert property (tx_go && !err_r && idx_r == 8'h00 |=>
        tx_sh_r[8:1] == HDR_READ) else $error("bad reply header");

endmodule : ccmh_top

//--- pkg/ccmh_pkg.sv
/*
 * constants, field layouts and carrier types for the config-mode
 * command handler. assumes a 40 mhz system clock.
 */
package ccmh_pkg;

    // ****************************************
    // command bytes and register map
    // ****************************************
    localparam logic [7:0] HDR_WRITE = 8'hc0;
    localparam logic [7:0] HDR_READ = 8'hc1;
    localparam logic [7:0] HDR_TEMP = 8'hc2;
    localparam logic [7:0] ERR_BYTE = 8'hff;
    localparam logic [7:0] REG_ADDR_HI = 8'h00;
    localparam logic [7:0] REG_ADDR_LO = 8'h01;
    localparam logic [7:0] REG_SER_AIR = 8'h02;
    localparam logic [8:0] REG_COUNT = 9'h003;
    localparam logic [7:0] RST_ADDR_HI = 8'h00;
    localparam logic [7:0] RST_ADDR_LO = 8'h00;
    localparam logic [7:0] RST_SER_AIR = 8'h62;
    localparam logic [15:0] BCAST_ADDR = 16'hffff;

    // ****************************************
    // fields of the serial and air byte
    // ****************************************
    localparam int BAUD_MSB = 7;
    localparam int BAUD_LSB = 5;
    localparam int PAR_MSB = 4;
    localparam int PAR_LSB = 3;
    localparam int AIR_MSB = 2;
    localparam int AIR_LSB = 0;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ALIAS = 2'h3;
    localparam logic [2:0] AIR_SLOWEST = 3'h2;
    localparam logic [16:0] BAUD_TAB [8] = '{17'h004b0, 17'h00960,
        17'h012c0, 17'h02580, 17'h04b00, 17'h09600, 17'h0e100, 17'h1c200};

    // ****************************************
    // modes
    // ****************************************
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_WOR_TX = 2'h1;
    localparam logic [1:0] MODE_CONFIG = 2'h3;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int CFG_BAUD = 9600;
    localparam int SWITCH_TIME_US = 1000;
    localparam int RECONF_TIME_US = 100;
    localparam int SWITCH_CYC = (CLK_HZ / 1_000_000) * SWITCH_TIME_US;
    localparam int RECONF_CYC = (CLK_HZ / 1_000_000) * RECONF_TIME_US;
    localparam int BIT_CYC = (CLK_HZ + CFG_BAUD / 2) / CFG_BAUD;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] STOP_BIT = 4'h9;

    // parameter bank carrier
    typedef struct packed {
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] ser_air;
    } ccmh_cfg_s;

    localparam ccmh_cfg_s CFG_RST = '{RST_ADDR_HI, RST_ADDR_LO, RST_SER_AIR};

endpackage : ccmh_pkg

//--- verif/ccmh_host.sv
/*
 * host microcontroller model for the config-mode command handler:
 * drives the mode pins and the serial input, collects reply bytes.
 * assumes the device runs 8n1 at BIT_CYCLES clocks per bit.
 */
`timescale 1ns/1ps
module ccmh_host #(
    parameter int BIT_CYCLES = 16
) (
    // clock
    input wire logic clock,
    // device outputs seen by the host
    input wire logic uart_txd,
    input wire logic aux_ready,
    // pins driven by the host
    output logic uart_rxd,
    output logic mode_select_low,
    output logic mode_select_high
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_b;
    int frame_err;

    // idle line high, pins select configuration mode
    initial begin
        uart_rxd = 1'b1;
        mode_select_low = 1'b1;
        mode_select_high = 1'b1;
        frame_err = 0;
    end

    // ****************************************
    // serial send and receive
    // ****************************************
    // one 8n1 frame, lsb first, fixed command rate
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            #1 uart_rxd = f[i];
            repeat (BIT_CYCLES - 1) @(posedge clock);
        end
    endtask : send_byte

    // mid-bit sampler for reply frames
    always begin
        @(negedge uart_txd);
        repeat (BIT_CYCLES / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clock);
            rx_b[i] = uart_txd;
        end
        repeat (BIT_CYCLES) @(posedge clock);
        if (uart_txd !== 1'b1) frame_err++;
        rx_q.push_back(rx_b);
    end

    // ****************************************
    // mode pins and busy indicator
    // ****************************************
    // change both mode pins just after an edge
    task automatic set_mode(input logic [1:0] m);
        @(posedge clock);
        #1 {mode_select_high, mode_select_low} = m;
    endtask : set_mode

    // wait for the busy indicator to read high, bounded
    task automatic wait_busy_rise(input int limit, output int n);
        n = 0;
        while (aux_ready !== 1'b1 && n < limit) begin
            @(posedge clock);
            #1 n++;
        end
    endtask : wait_busy_rise
endmodule : ccmh_host

//--- verif/tb_top.sv
/*
 * self-checking bench for the config-mode command handler.
 * assumes shortened bit, switch and reconfiguration counts.
 */
`timescale 1ns/1ps
module tb_top;
    import ccmh_pkg::*;
    localparam int BITC = 16;
    localparam int SWC = 20;
    localparam int RCC = 10;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic xfer_pending = 1'b0;
    logic uart_rxd, mode_select_low, mode_select_high, uart_txd, aux_ready;
    logic [1:0] cur_mode, uart_parity;
    logic radio_tx_en, radio_rx_en, addr_filter_en;
    logic [16:0] uart_baud;
    logic [2:0] air_rate_sel;
    logic [15:0] node_address;
    ccmh_cfg_s retained_cfg;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    // ****************************************
    // clock, device and host
    // ****************************************
    always #12.5 clock = ~clock;

    ccmh_top #(.BIT_CYCLES(BITC), .SWITCH_CYCLES(SWC),
        .RECONF_CYCLES(RCC)) uut (.clock(clock), .sys_rst(sys_rst),
        .mode_select_low(mode_select_low),
        .mode_select_high(mode_select_high), .xfer_pending(xfer_pending),
        .uart_rxd(uart_rxd), .uart_txd(uart_txd), .aux_ready(aux_ready),
        .cur_mode(cur_mode), .radio_tx_en(radio_tx_en),
        .radio_rx_en(radio_rx_en), .uart_baud(uart_baud),
        .uart_parity(uart_parity), .air_rate_sel(air_rate_sel),
        .node_address(node_address), .addr_filter_en(addr_filter_en),
        .retained_cfg(retained_cfg));

    ccmh_host #(.BIT_CYCLES(BITC)) host (.clock(clock), .uart_txd(uart_txd),
        .aux_ready(aux_ready), .uart_rxd(uart_rxd),
        .mode_select_low(mode_select_low),
        .mode_select_high(mode_select_high));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic stop_test();
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [23:0] exp,
            input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // send a command, collect and compare the whole reply
    task automatic xfer(input logic [63:0] tx, input int nt,
            input logic [63:0] rx, input int nr);
        int n;
        host.rx_q.delete();
        for (int i = nt - 1; i >= 0; i--) host.send_byte(tx[8*i +: 8]);
        n = 0;
        while (host.rx_q.size() < nr && n < 20 * BITC * (nr + 1)) begin
            @(posedge clock);
            #1 n++;
        end
        // let the last stop bit finish so the device is idle on return
        repeat (BITC) @(posedge clock);
        #1;
        host.wait_busy_rise(4 * BITC, n);
        chk("reply_count", 24'(nr), 24'(host.rx_q.size()));
        for (int i = 0; i < nr && i < host.rx_q.size(); i++)
            chk("reply_byte", 24'(rx[8*(nr-1-i) +: 8]), 24'(host.rx_q[i]));
    endtask : xfer

    // cycles from now until the applied mode reads m
    task automatic wait_mode(input logic [1:0] m, output int n);
        n = 0;
        while (cur_mode !== m && n < 8 * SWC) begin
            @(posedge clock);
            #1 n++;
        end
    endtask : wait_mode

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk("retained", CFG_RST, retained_cfg);
        chk("mode", 24'(MODE_CONFIG), 24'(cur_mode));
        chk("radio_en", 24'h0, 24'({radio_tx_en, radio_rx_en}));
        chk("txd_idle", 24'h1, 24'(uart_txd));
    endtask : t_reset

    task automatic t_read();
        xfer(64'hc10003, 3, 64'hc10003000062, 6);
        xfer(64'hc10102, 3, 64'hc101020062, 5);
    endtask : t_read

    task automatic t_write();
        xfer(64'hc000021234, 5, 64'hc100021234, 5);
        chk("retained_addr", 24'h123462, retained_cfg);
        xfer(64'hc10002, 3, 64'hc100021234, 5);
        chk("baud_held", 24'h02580, 24'(uart_baud));
        chk("addr_held", 24'h0, 24'(node_address));
    endtask : t_write

    task automatic t_temp();
        xfer(64'hc20201fd, 4, 64'hc10201fd, 4);
        chk("retained_cfg", 24'h123462, retained_cfg);
        xfer(64'hc10201, 3, 64'hc10201fd, 4);
    endtask : t_temp

    task automatic t_bad();
        xfer(64'h55, 1, 64'hffffff, 3);
        xfer(64'hc10202, 3, 64'hffffff, 3);
        xfer(64'hc00000, 3, 64'hffffff, 3);
        xfer(64'hc10003, 3, 64'hc100031234fd, 6);
    endtask : t_bad

    task automatic t_leave();
        int n;
        host.set_mode(2'h0);
        wait_mode(MODE_NORMAL, n);
        chk("switch_ok", 24'h1, 24'(n >= SWC - 1 && n <= SWC + 1));
        chk("busy_low", 24'h0, 24'(aux_ready));
        host.wait_busy_rise(4 * RCC, n);
        chk("reconf_ok", 24'h1, 24'(n >= RCC && n <= RCC + 2));
        chk("baud", 24'h1c200, 24'(uart_baud));
        chk("parity", 24'h0, 24'(uart_parity));
        chk("air", 24'h5, 24'(air_rate_sel));
        chk("addr", 24'h1234, 24'(node_address));
        chk("filter", 24'h1, 24'(addr_filter_en));
        chk("radio_en", 24'h3, 24'({radio_tx_en, radio_rx_en}));
        chk("retained", 24'h123462, retained_cfg);
    endtask : t_leave

    task automatic t_bcast();
        int n;
        host.set_mode(2'h3);
        wait_mode(MODE_CONFIG, n);
        host.wait_busy_rise(8 * RCC, n);
        chk("radio_rx", 24'h0, 24'(radio_rx_en));
        xfer(64'hc20003ffff10, 6, 64'hc10003ffff10, 6);
        xfer_pending = 1'b1;
        host.set_mode(2'h1);
        repeat (3 * SWC) @(posedge clock);
        chk("deferred", 24'(MODE_CONFIG), 24'(cur_mode));
        #1 xfer_pending = 1'b0;
        wait_mode(MODE_WOR_TX, n);
        chk("switch_ok", 24'h1, 24'(n >= SWC - 1 && n <= SWC + 1));
        host.wait_busy_rise(4 * RCC, n);
        chk("filter", 24'h0, 24'(addr_filter_en));
        chk("air", 24'h2, 24'(air_rate_sel));
        chk("baud", 24'h004b0, 24'(uart_baud));
        chk("parity", 24'h2, 24'(uart_parity));
        chk("radio_tx", 24'h1, 24'(radio_tx_en));
    endtask : t_bcast

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clock);
        #1 sys_rst = 1'b0;
        @(posedge clock);
        #1;
        t_reset();
        t_read();
        t_write();
        t_temp();
        t_bad();
        t_leave();
        t_bcast();
        chk("stop_bits", 24'h0, 24'(host.frame_err));
        stop_test();
    end
endmodule : tb_top
